// File: dcs_core.sv
`timescale 1ns/1ps

module dcs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge core_clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // dcs_fifo

module dcs_core
  import dcs_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                conv_start_strobe,
  input  wire logic                cs_n,
  input  wire logic                rd,
  input  wire logic                serial_cmd_in,
  input  wire logic                output_select_pin,
  input  wire logic                channel_select_pin,
  input  wire logic [RES_BITS-1:0] conv_value_a,
  input  wire logic [RES_BITS-1:0] conv_value_b,
  output logic                     busy,
  output logic                     hold,
  output logic                     precharge,
  output logic [1:0]               mux_sel,
  output logic                     result_out_a,
  output logic                     result_out_a_oe,
  output logic                     result_out_b,
  output logic                     result_out_b_oe
);
  dcs_state_type        state_q, state_d;
  logic [3:0]           cyc_q;
  logic                 start_q;
  logic                 rd_q;
  logic                 busy_q;
  logic                 hold_q;
  logic                 prechg_q;
  logic [1:0]           mux_q;
  logic                 pair_tog_q;
  logic [1:0]           cmd_sel_q;
  logic [CMD_BITS-1:0]  cmd_sh_q;
  logic [4:0]           cmd_cnt_q;
  logic [PAIR_BITS-1:0] out_sh_q;
  logic [4:0]           out_cnt_q;
  logic                 sdo_a_q;
  logic                 sdo_b_q;
  logic                 oe_q;
  dcs_pair_type         fifo_in;
  dcs_pair_type         fifo_out;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;

  wire start_rise = conv_start_strobe && !start_q;
  wire accept     = start_rise && state_q == ST_SAMPLE && fifo_in_ready;
  wire conv_done  = state_q == ST_CONV && cyc_q == 4'(CONV_CYC - 1);
  wire frame      = rd && !rd_q && !cs_n;
  wire pop        = frame && fifo_out_valid;
  wire dual       = output_select_pin;
  wire [4:0] out_len = dual ? 5'(RES_BITS) : 5'(PAIR_BITS);
  wire [1:0] mux_next = channel_select_pin ? (pair_tog_q ? MUX_PAIR1 : MUX_PAIR0) : cmd_sel_q;
  wire cmd_last   = cmd_cnt_q == 5'h01;
  wire [CMD_BITS-1:0] cmd_word = {cmd_sh_q[CMD_BITS-2:0], serial_cmd_in};

  assign fifo_in.a = conv_value_a;
  assign fifo_in.b = conv_value_b;

  dcs_fifo #(.WIDTH(PAIR_BITS), .DEPTH(FIFO_WORDS)) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_data   (fifo_in),
    .in_valid  (conv_done),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (pop)
  );

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SAMPLE: if (accept) state_d = ST_CONV;
      ST_CONV:   if (conv_done) state_d = ST_PRECHG;
      ST_PRECHG: if (cyc_q == 4'(PRECHG_CYC - 1)) state_d = ST_SAMPLE;
      default:   state_d = ST_SAMPLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q  <= ST_SAMPLE;
      cyc_q    <= '0;
      start_q  <= 1'b0;
      busy_q   <= 1'b0;
      hold_q   <= 1'b0;
      prechg_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cyc_q    <= (state_d != state_q) ? '0 : cyc_q + 1'b1;
      start_q  <= conv_start_strobe;
      hold_q   <= state_d == ST_CONV;
      busy_q   <= state_d == ST_CONV;
      prechg_q <= state_d == ST_PRECHG;
    end
  end

  // Pair alternates per conversion, mux only moves while sampling
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mux_q      <= MUX_RESET;
      pair_tog_q <= 1'b0;
    end else begin
      if (conv_done) pair_tog_q <= !pair_tog_q;
      if (state_d == ST_SAMPLE) mux_q <= mux_next;
    end
  end

  // Command shift-in framed by the read strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_q      <= 1'b0;
      cmd_sh_q  <= '0;
      cmd_cnt_q <= '0;
      cmd_sel_q <= MUX_RESET;
    end else begin
      rd_q <= rd;
      if (frame) begin
        cmd_cnt_q <= 5'(CMD_BITS);
      end else if (cmd_cnt_q != '0) begin
        cmd_sh_q  <= cmd_word;
        cmd_cnt_q <= cmd_cnt_q - 1'b1;
        if (cmd_last) cmd_sel_q <= {cmd_word[CMD_CHSEL_HI_POS], cmd_word[CMD_CHSEL_LO_POS]};
      end
    end
  end

  // Result shift-out, launched on rising edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_sh_q  <= '0;
      out_cnt_q <= '0;
      sdo_a_q   <= 1'b0;
      sdo_b_q   <= 1'b0;
      oe_q      <= 1'b0;
    end else begin
      oe_q <= !cs_n;
      if (frame) begin
        out_sh_q  <= pop ? fifo_out : '0;
        out_cnt_q <= out_len;
        sdo_a_q   <= 1'b0;
        sdo_b_q   <= 1'b0;
      end else if (out_cnt_q != '0) begin
        sdo_a_q   <= out_sh_q[PAIR_BITS-1];
        sdo_b_q   <= dual ? out_sh_q[RES_BITS-1] : 1'b0;
        out_sh_q  <= {out_sh_q[PAIR_BITS-2:0], 1'b0};
        out_cnt_q <= out_cnt_q - 1'b1;
      end else begin
        sdo_a_q <= 1'b0;
        sdo_b_q <= 1'b0;
      end
    end
  end

  assign busy            = busy_q;
  assign hold            = hold_q;
  assign precharge       = prechg_q;
  assign mux_sel         = mux_q;
  assign result_out_a    = sdo_a_q;
  assign result_out_b    = sdo_b_q;
  assign result_out_a_oe = oe_q;
  assign result_out_b_oe = oe_q;

  localparam int CONV_LAST = CONV_CYC - 1;

  hold_on_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept |=> hold_q && busy_q) else $error("start edge did not hold inputs");
  busy_length_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(busy_q) |-> busy_q [*8] ##1 busy_q [*4] ##1 !busy_q) else $error("busy length wrong");
  oe_follows_cs_a: assert property (@(posedge core_clk) disable iff (!nrst)
    result_out_a_oe == !$past(cs_n) && result_out_b_oe == !$past(cs_n)) else $error("enable not following cs");
  rd_gated_cs_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(rd) && cs_n && out_cnt_q == '0 |=> out_cnt_q == '0) else $error("read accepted with cs high");
  dual_b_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
    pop && dual |=> ##1 (sdo_a_q == $past(fifo_out.a[RES_BITS-1], 2)) && (sdo_b_q == $past(fifo_out.b[RES_BITS-1], 2)))
    else $error("dual mode first bits wrong");
  single_a_out_a: assert property (@(posedge core_clk) disable iff (!nrst)
    out_cnt_q != '0 && !frame && !dual |=> !sdo_b_q) else $error("b output active in single mode");
  start_same_edge_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == ST_SAMPLE && start_rise && fifo_in_ready |=> state_q == ST_CONV) else $error("start edge missed");
  precharge_one_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(busy_q) |-> prechg_q ##1 !prechg_q && !busy_q) else $error("precharge not one cycle");
  conv_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
    state_q == ST_CONV |-> cyc_q <= 4'(CONV_LAST)) else $error("conversion overran");
  mux_still_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busy_q && $past(busy_q) |-> $stable(mux_q)) else $error("mux moved during conversion");

  conv_seen_c: cover property (@(posedge core_clk) disable iff (!nrst) conv_done);
  dual_read_c: cover property (@(posedge core_clk) disable iff (!nrst) pop && dual);
  single_read_c: cover property (@(posedge core_clk) disable iff (!nrst) pop && !dual);
  fifo_full_c: cover property (@(posedge core_clk) disable iff (!nrst) !fifo_in_ready);
endmodule // dcs_core

// File: dcs_pkg.sv
package dcs_pkg;

  localparam int RES_BITS          = 12;
  localparam int CONV_CYC          = 12;
  localparam int PRECHG_CYC        = 1;
  localparam int MIN_CONV_CLOCKS   = 16;
  localparam int CLK_PERIOD_PS     = 50000;
  localparam int START_SETUP_NS    = 12;
  localparam int START_SETUP_CYC   = (START_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FIFO_DEPTH        = 32;
  localparam int CMD_BITS          = 16;
  localparam int CMD_CHSEL_HI_POS  = 15;
  localparam int CMD_CHSEL_LO_POS  = 14;
  localparam int PAIR_BITS         = 2 * RES_BITS;
  localparam logic [1:0] MUX_PAIR0 = 2'h0;
  localparam logic [1:0] MUX_PAIR1 = 2'h3;
  localparam logic [1:0] MUX_RESET = 2'h0;

  typedef struct packed {
    logic [RES_BITS-1:0] a;
    logic [RES_BITS-1:0] b;
  } dcs_pair_type;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_CONV   = 2'b01,
    ST_PRECHG = 2'b10
  } dcs_state_type;

endpackage

// File: dcs_host_model.sv
`timescale 1ns/1ps

module dcs_host_model (
  input  wire logic core_clk,
  input  wire logic busy,
  input  wire logic precharge,
  input  wire logic result_out_a,
  input  wire logic result_out_a_oe,
  input  wire logic result_out_b,
  input  wire logic result_out_b_oe,
  output logic      conv_start_strobe,
  output logic      cs_n,
  output logic      rd,
  output logic      serial_cmd_in
);
  logic line_a;
  logic line_b;
  logic last_a = 1'b0;
  logic last_b = 1'b0;

  // Released outputs read back as a toggling level
  assign line_a = result_out_a_oe ? result_out_a : ~last_a;
  assign line_b = result_out_b_oe ? result_out_b : ~last_b;

  always @(posedge core_clk) begin
    last_a <= line_a;
    last_b <= line_b;
  end

  initial begin
    conv_start_strobe = 1'b0;
    cs_n = 1'b1;
    rd = 1'b0;
    serial_cmd_in = 1'b0;
  end

  // Start raised at a rising edge, only after the previous 16-clock slot
  task automatic do_conv(output logic [15:0] busy_v, output logic [15:0] prec_v);
    @(posedge core_clk);
    conv_start_strobe <= 1'b1;
    @(posedge core_clk);
    conv_start_strobe <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      busy_v[i] = busy;
      prec_v[i] = precharge;
      @(posedge core_clk);
    end
  endtask

  // Result bits captured on the falling edge
  task automatic do_read(input logic sel, input logic [15:0] cmd, input int nbits,
                         output logic [23:0] a_q, output logic [23:0] b_q);
    a_q = 24'h000000;
    b_q = 24'h000000;
    @(posedge core_clk);
    cs_n <= !sel;
    @(posedge core_clk);
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    for (int i = 0; i < 26; i++) begin
      serial_cmd_in <= (i < 16) ? cmd[15-i] : 1'b0;
      @(negedge core_clk);
      if (i >= 1 && i - 1 < nbits) begin
        a_q = {a_q[22:0], line_a};
        b_q = {b_q[22:0], line_b};
      end
      @(posedge core_clk);
    end
    cs_n <= 1'b1;
  endtask
endmodule // dcs_host_model

// File: dcs_core_tb_top.sv
`timescale 1ns/1ps

module dcs_core_tb_top;
  import dcs_pkg::*;
  logic core_clk = 1'b0;
  logic nrst;
  logic output_select_pin;
  logic channel_select_pin;
  logic [RES_BITS-1:0] conv_value_a;
  logic [RES_BITS-1:0] conv_value_b;
  logic conv_start_strobe, cs_n, rd, serial_cmd_in, busy, hold, precharge;
  logic result_out_a, result_out_a_oe, result_out_b, result_out_b_oe;
  logic [1:0] mux_sel;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] lfsr_q = 32'h1B998E6E;
  dcs_pair_type exp_q[$];
  dcs_pair_type p;
  logic [15:0] bv, pv;
  logic [23:0] a_q, b_q;
  logic [1:0] m_prev;
  logic sel;
  logic [1:0] codes [3] = '{2'h1, 2'h3, 2'h0};

  always #25 core_clk = ~core_clk;

  dcs_core #(.FIFO_WORDS(FIFO_DEPTH)) dcs_core_i (.core_clk(core_clk), .nrst(nrst),
    .conv_start_strobe(conv_start_strobe), .cs_n(cs_n), .rd(rd), .serial_cmd_in(serial_cmd_in),
    .output_select_pin(output_select_pin), .channel_select_pin(channel_select_pin),
    .conv_value_a(conv_value_a), .conv_value_b(conv_value_b), .busy(busy), .hold(hold),
    .precharge(precharge), .mux_sel(mux_sel), .result_out_a(result_out_a),
    .result_out_a_oe(result_out_a_oe), .result_out_b(result_out_b), .result_out_b_oe(result_out_b_oe));

  dcs_host_model dcs_host_model_i (.core_clk(core_clk), .busy(busy), .precharge(precharge),
    .result_out_a(result_out_a), .result_out_a_oe(result_out_a_oe), .result_out_b(result_out_b),
    .result_out_b_oe(result_out_b_oe), .conv_start_strobe(conv_start_strobe), .cs_n(cs_n),
    .rd(rd), .serial_cmd_in(serial_cmd_in));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [23:0] exp_a(input logic m, input dcs_pair_type v);
    return m ? {12'h000, v.a} : {v.a, v.b};
  endfunction

  function automatic logic [23:0] exp_b(input logic m, input dcs_pair_type v);
    return m ? {12'h000, v.b} : 24'h000000;
  endfunction

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge core_clk);
    error_cnt++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    report_and_stop();
  end

  initial begin
    nrst = 1'b0;
    output_select_pin = 1'b1;
    channel_select_pin = 1'b1;
    conv_value_a = 12'h000;
    conv_value_b = 12'h000;
    repeat (8) @(posedge core_clk);
    check("reset_outs", 24'({busy, hold, precharge, mux_sel, result_out_a_oe, result_out_b_oe}), 24'h0);
    nrst <= 1'b1;
    // Fill the buffer, last start is refused
    for (int i = 0; i < 33; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      p = lfsr_q[23:0];
      @(posedge core_clk);
      conv_value_a <= p.a;
      conv_value_b <= p.b;
      dcs_host_model_i.do_conv(bv, pv);
      @(negedge core_clk);
      check("busy_window", 24'(bv), i < 32 ? 24'h000FFF : 24'h000000);
      check("precharge_window", 24'(pv), i < 32 ? 24'h001000 : 24'h000000);
      if (i > 0 && i < 32) check("mux_alternate", 24'(mux_sel), 24'(m_prev ^ 2'h3));
      if (i < 32) exp_q.push_back(p);
      m_prev = mux_sel;
    end
    // Frame without chip select must not pop
    dcs_host_model_i.do_read(1'b0, 16'h0000, 12, a_q, b_q);
    @(posedge core_clk);
    channel_select_pin <= 1'b0;
    for (int i = 0; i < 33; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      sel = lfsr_q[7];
      p = (i < 32) ? exp_q.pop_front() : 24'h000000;
      @(posedge core_clk);
      output_select_pin <= sel;
      dcs_host_model_i.do_read(1'b1, 16'h0000, sel ? 12 : 24, a_q, b_q);
      check("result_a", a_q, exp_a(sel, p));
      check("result_b", b_q, exp_b(sel, p));
      repeat (lfsr_q[3:0]) @(posedge core_clk);
    end
    foreach (codes[k]) begin
      dcs_host_model_i.do_read(1'b1, {codes[k], 14'h0000}, 12, a_q, b_q);
      @(negedge core_clk);
      check("mux_code", 24'(mux_sel), 24'(codes[k]));
    end
    report_and_stop();
  end
endmodule // dcs_core_tb_top
